/* rtl/soc_ep_pkg.sv */
// Package of register map, field layout and carrier types for the event prescaler
package soc_ep_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [11:0] SEP_ADDR_PRESCALE = 12'h000; // event_trigger_prescale
   localparam logic [11:0] SEP_ADDR_SELECT   = 12'h004; // event_trigger_select
   localparam logic [11:0] SEP_ADDR_FLAGS    = 12'h008; // event_trigger_flags (W1C)
   localparam logic [11:0] SEP_ADDR_MASK     = 12'h00c; // interrupt mask
   // ==========================================================
   // Field positions
   localparam int SEP_B_CNT_LSB = 14;
   localparam int SEP_B_PRD_LSB = 12;
   localparam int SEP_A_CNT_LSB = 10;
   localparam int SEP_A_PRD_LSB = 8;
   localparam int SEP_B_EN_BIT  = 15;
   localparam int SEP_B_SEL_LSB = 12;
   localparam int SEP_A_EN_BIT  = 11;
   localparam int SEP_A_SEL_LSB = 8;
   localparam int SEP_FLAG_A    = 0;
   localparam int SEP_FLAG_B    = 1;
   // ==========================================================
   // Reset values
   localparam logic [1:0] SEP_PRD_RESET = 2'h0;
   localparam logic [2:0] SEP_SEL_RESET = 3'h0;
   localparam logic [1:0] SEP_CNT_RESET = 2'h0;
   localparam logic [1:0] SEP_PRD_OFF   = 2'h0;
   // ==========================================================
   // Event source selections
   typedef enum logic [2:0] {
      SEP_EV_COMPARE   = 3'h0,
      SEP_EV_ZERO      = 3'h1,
      SEP_EV_PERIOD    = 3'h2,
      SEP_EV_ZERO_PRD  = 3'h3,
      SEP_EV_CMPA_UP   = 3'h4,
      SEP_EV_CMPA_DOWN = 3'h5,
      SEP_EV_CMPB_UP   = 3'h6,
      SEP_EV_CMPB_DOWN = 3'h7
   } sep_event_sel_type;
   // Time-base event strobes, one-cycle pulses on ref_clk
   typedef struct packed {
      logic compare_a;  // Compare-module event for channel A
      logic compare_b;  // Compare-module event for channel B
      logic ctr_zero;
      logic ctr_period;
      logic cmpa_up;
      logic cmpa_down;
      logic cmpb_up;
      logic cmpb_down;
   } sep_events_type;
   // One channel's state
   typedef struct packed {
      logic                   pulse_enable;
      sep_event_sel_type      event_select;
      logic [1:0]             event_period;
      logic [1:0]             event_count;
      logic                   start_pulse;
   } sep_chan_type;
   // Whole module state
   typedef struct packed {
      sep_chan_type chan_a;
      sep_chan_type chan_b;
      logic [1:0]   flags;
      logic [1:0]   mask;
      logic         irq;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } sep_state_type;
endpackage : soc_ep_pkg

/* rtl/soc_ep_prescaler.sv */
// Event prescaler issuing converter start-of-conversion pulses A and B
// Contract
// - Bits 15-14 of the prescale register read the channel-B event count, 0 to 3.
// - The B period select in bits 13-12 fires on event 1, 2 or 3 for codes 01, 10, 11.
// - A B period select of 00 stops the B counter and never yields a B pulse.
// - A B pulse appears only while the B pulse enable bit is 1.
// - A set B status flag does not hold back a B pulse.
// - Issuing a B pulse clears the B event counter by hardware.
// - Bits 11-10 of the prescale register read the channel-A event count, 0 to 3.
// - The A period select in bits 9-8 sets how many A events precede an A pulse.
// - An A pulse appears only while the A pulse enable bit is 1.
// - A set A status flag does not hold back an A pulse.
// - Issuing an A pulse clears the A event counter by hardware.
// - A period code 00 disables A, and 01, 10, 11 fire on event 1, 2, 3.
// - The 3-bit event select picks compare, zero, period, both, or CMPA/CMPB up/down.
`timescale 1ns/100ps
module soc_ep_prescaler (
   input  wire logic                       ref_clk,
   input  wire logic                       reset_n,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire soc_ep_pkg::sep_events_type tb_events,
   output logic                            conv_a_start_pulse,
   output logic                            conv_b_start_pulse,
   output logic                            irq
);
   import soc_ep_pkg::*;

   sep_state_type state;
   sep_state_type next_state;

   // ==========================================================
   // Helpers
   // Decode the selected event strobe for one channel
   function automatic logic event_hit(input sep_event_sel_type sel,
                                      input logic              compare_ev,
                                      input sep_events_type    ev);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         SEP_EV_COMPARE:   hit = compare_ev;
         SEP_EV_ZERO:      hit = ev.ctr_zero;
         SEP_EV_PERIOD:    hit = ev.ctr_period;
         SEP_EV_ZERO_PRD:  hit = ev.ctr_zero | ev.ctr_period;
         SEP_EV_CMPA_UP:   hit = ev.cmpa_up;
         SEP_EV_CMPA_DOWN: hit = ev.cmpa_down;
         SEP_EV_CMPB_UP:   hit = ev.cmpb_up;
         SEP_EV_CMPB_DOWN: hit = ev.cmpb_down;
      endcase
      return hit;
   endfunction

   // Advance one channel's counter and raise its pulse when the period is met
   function automatic sep_chan_type chan_step(input sep_chan_type ch, input logic hit);
      sep_chan_type nx;
      logic [1:0]   cnt;
      nx             = ch;
      nx.start_pulse = 1'b0;
      cnt            = ch.event_count;
      if (ch.event_period == SEP_PRD_OFF) begin
         nx.event_count = cnt;
      end else begin
         if (hit && cnt < ch.event_period) begin
            cnt = cnt + 2'h1;
         end
         // Pulse independent of the status flag; a period written at or
         // below the count also fires once and clears the count
         if (cnt >= ch.event_period && ch.pulse_enable) begin
            nx.start_pulse = 1'b1;
            cnt            = SEP_CNT_RESET;
         end
         nx.event_count = cnt;
      end
      return nx;
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic       hit_a;
      logic       hit_b;
      logic       taken;
      logic       wr;
      logic       rd;
      logic [1:0] set_flags;
      next_state = state;
      set_flags  = 2'h0;
      hit_a      = event_hit(state.chan_a.event_select, tb_events.compare_a, tb_events);
      hit_b      = event_hit(state.chan_b.event_select, tb_events.compare_b, tb_events);
      // Request taken in the first access cycle; a write lands at the edge that sees pready
      taken      = psel && penable && !state.pready;
      wr         = psel && penable && pwrite && state.pready;
      rd         = taken && !pwrite;
      // Register writes take effect before the counters step
      next_state.pready  = taken;
      next_state.pslverr = taken && !(paddr == SEP_ADDR_PRESCALE || paddr == SEP_ADDR_SELECT ||
                                      paddr == SEP_ADDR_FLAGS || paddr == SEP_ADDR_MASK);
      if (wr) begin
         unique case (paddr)
            SEP_ADDR_PRESCALE: begin
               next_state.chan_b.event_period = pwdata[SEP_B_PRD_LSB +: 2];
               next_state.chan_a.event_period = pwdata[SEP_A_PRD_LSB +: 2];
            end
            SEP_ADDR_SELECT: begin
               next_state.chan_b.pulse_enable = pwdata[SEP_B_EN_BIT];
               next_state.chan_b.event_select =
                  sep_event_sel_type'(pwdata[SEP_B_SEL_LSB +: 3]);
               next_state.chan_a.pulse_enable = pwdata[SEP_A_EN_BIT];
               next_state.chan_a.event_select =
                  sep_event_sel_type'(pwdata[SEP_A_SEL_LSB +: 3]);
            end
            SEP_ADDR_FLAGS: next_state.flags = state.flags & ~pwdata[1:0];
            SEP_ADDR_MASK:  next_state.mask  = pwdata[1:0];
            default:        next_state.pslverr = 1'b0;
         endcase
      end
      // Read data mux
      if (rd) begin
         next_state.prdata = 32'h0;
         unique case (paddr)
            SEP_ADDR_PRESCALE: begin
               next_state.prdata[SEP_B_CNT_LSB +: 2] = state.chan_b.event_count;
               next_state.prdata[SEP_B_PRD_LSB +: 2] = state.chan_b.event_period;
               next_state.prdata[SEP_A_CNT_LSB +: 2] = state.chan_a.event_count;
               next_state.prdata[SEP_A_PRD_LSB +: 2] = state.chan_a.event_period;
            end
            SEP_ADDR_SELECT: begin
               next_state.prdata[SEP_B_EN_BIT]        = state.chan_b.pulse_enable;
               next_state.prdata[SEP_B_SEL_LSB +: 3]  = state.chan_b.event_select;
               next_state.prdata[SEP_A_EN_BIT]        = state.chan_a.pulse_enable;
               next_state.prdata[SEP_A_SEL_LSB +: 3]  = state.chan_a.event_select;
            end
            SEP_ADDR_FLAGS: next_state.prdata[1:0] = state.flags;
            SEP_ADDR_MASK:  next_state.prdata[1:0] = state.mask;
            default:        next_state.pslverr     = 1'b1;
         endcase
      end
      // Channel counters and pulses
      next_state.chan_a = chan_step(next_state.chan_a, hit_a);
      next_state.chan_b = chan_step(next_state.chan_b, hit_b);
      // Sticky flags: a pulse sets its flag even if set already, set wins over clear
      set_flags[SEP_FLAG_A]       = next_state.chan_a.start_pulse;
      set_flags[SEP_FLAG_B]       = next_state.chan_b.start_pulse;
      next_state.flags            = next_state.flags | set_flags;
      next_state.irq              = |(next_state.flags & next_state.mask);
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops
   assign prdata             = state.prdata;
   assign pready             = state.pready;
   assign pslverr            = state.pslverr;
   assign conv_a_start_pulse = state.chan_a.start_pulse;
   assign conv_b_start_pulse = state.chan_b.start_pulse;
   assign irq                = state.irq;
endmodule // soc_ep_prescaler

/* test/sep_conv_model.sv */
// Converter trigger input model that counts start pulse cycles
`timescale 1ns/100ps
module sep_conv_model (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic conv_a_start_pulse,
   input  wire logic conv_b_start_pulse,
   output int        a_count,
   output int        b_count
);
   // Each high cycle counts once, so a wide pulse shows as extra starts
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_count <= 0;
         b_count <= 0;
      end else begin
         a_count <= a_count + int'(conv_a_start_pulse);
         b_count <= b_count + int'(conv_b_start_pulse);
      end
   end
endmodule // sep_conv_model

/* test/sep_monitor.sv */
// Checker of bus answer, start pulse and interrupt timing
`timescale 1ns/100ps
module sep_monitor (
   input wire logic                       ref_clk,
   input wire logic                       reset_n,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [11:0]                paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire soc_ep_pkg::sep_events_type tb_events,
   input wire logic                       conv_a_start_pulse,
   input wire logic                       conv_b_start_pulse,
   input wire logic                       irq
);
   import soc_ep_pkg::*;
   // ==========================================================
   // Properties on the one clock domain
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_rdy_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_rdy_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer");
   a_rdy_access: assert property (pready |-> psel && penable) else $error("stray pready");
   a_err_rdy: assert property (pslverr |-> pready) else $error("stray pslverr");
   a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite) else $error("prdata");
   a_pulse_a_cause: assert property (conv_a_start_pulse |-> $past(|tb_events) ||
      $past(pwrite && penable) || $past(pwrite && penable, 2)) else $error("stray pulse a");
   a_pulse_b_cause: assert property (conv_b_start_pulse |-> $past(|tb_events) ||
      $past(pwrite && penable) || $past(pwrite && penable, 2)) else $error("stray pulse b");
   a_irq_rise: assert property ($rose(irq) |-> $past(penable && pwrite) ||
      conv_a_start_pulse || conv_b_start_pulse) else $error("stray irq");
endmodule // sep_monitor

bind soc_ep_prescaler sep_monitor mon (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tb_events(tb_events), .irq(irq),
   .conv_a_start_pulse(conv_a_start_pulse), .conv_b_start_pulse(conv_b_start_pulse));

/* test/tb.sv */
// Self-checking bench for the event prescaler
`timescale 1ns/100ps
module tb;
   import soc_ep_pkg::*;
   logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, pa, pb, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  ev;
   int          bad_count, tests_run, ac, bc, sh;
   int          e[2];
   int          evbit[8] = '{7, 5, 4, 5, 3, 2, 1, 0};
   // ==========================================================
   // Clock, design, converter model and watchdog
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   soc_ep_prescaler dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tb_events(ev), .conv_a_start_pulse(pa), .conv_b_start_pulse(pb),
      .irq(irq));
   sep_conv_model conv (.ref_clk(ref_clk), .reset_n(reset_n), .conv_a_start_pulse(pa),
      .conv_b_start_pulse(pb), .a_count(ac), .b_count(bc));
   initial begin
      repeat (4000) @(posedge ref_clk);
      bad_count++;
      report_and_stop();
   end
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bus transfer held until pready is sampled high, then one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'h1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1'h1;
      @(posedge ref_clk iff pready);
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask
   // Strobe one event line for n cycles in a row, then let pulses settle
   task automatic fire(input int b, input int n);
      if (n > 0) begin
         ev[b] <= 1'h1;
         repeat (n) @(posedge ref_clk);
         ev[b] <= 1'h0;
      end
      repeat (3) @(posedge ref_clk);
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev} = '0;
      reset_n = 1'h0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      apb(1'h0, SEP_ADDR_PRESCALE, 32'h0);
      check(rd, 32'h0);
      apb(1'h0, SEP_ADDR_SELECT, 32'h0);
      check(rd, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      check(err, 32'h1);
      for (int c = 0; c < 2; c++) begin
         sh = 4 * c;
         apb(1'h1, SEP_ADDR_SELECT, 32'h9 << (8 + sh));
         for (int p = 1; p < 4; p++) begin
            apb(1'h1, SEP_ADDR_PRESCALE, p << (8 + sh));
            fire(5, p - 1);
            apb(1'h0, SEP_ADDR_PRESCALE, 32'h0);
            check(rd, ((p - 1) << 10 | p << 8) << sh);
            fire(5, 1);
            e[c]++;
            check(c ? bc : ac, e[c]);
            apb(1'h0, SEP_ADDR_PRESCALE, 32'h0);
            check(rd, p << (8 + sh));
         end
         apb(1'h1, SEP_ADDR_PRESCALE, 32'h1 << (8 + sh));
         for (int s = 0; s < 8; s++) begin
            apb(1'h1, SEP_ADDR_SELECT, (8 | s) << (8 + sh));
            fire((s == 0 && c == 1) ? 6 : evbit[s], 1);
            e[c]++;
            check(c ? bc : ac, e[c]);
         end
         apb(1'h1, SEP_ADDR_SELECT, 32'h9 << (8 + sh));
         apb(1'h1, SEP_ADDR_PRESCALE, 32'h0);
         fire(5, 3);
         check(c ? bc : ac, e[c]);
         apb(1'h0, SEP_ADDR_PRESCALE, 32'h0);
         check(rd, 32'h0);
         apb(1'h1, SEP_ADDR_SELECT, 32'h1 << (8 + sh));
         apb(1'h1, SEP_ADDR_PRESCALE, 32'h1 << (8 + sh));
         fire(5, 2);
         check(c ? bc : ac, e[c]);
         apb(1'h0, SEP_ADDR_PRESCALE, 32'h0);
         check(rd, 32'h5 << (8 + sh));
         apb(1'h1, SEP_ADDR_SELECT, 32'h9 << (8 + sh));
         fire(5, 0);
         e[c]++;
         check(c ? bc : ac, e[c]);
      end
      apb(1'h0, SEP_ADDR_FLAGS, 32'h0);
      check(rd, 32'h3);
      apb(1'h1, SEP_ADDR_MASK, 32'h1);
      check(irq, 32'h1);
      apb(1'h1, SEP_ADDR_FLAGS, 32'h1);
      check(irq, 32'h0);
      apb(1'h0, SEP_ADDR_FLAGS, 32'h0);
      check(rd, 32'h2);
      report_and_stop();
   end
endmodule // tb
